// ===== core/rst_ctl_pkg.sv
package rst_ctl_pkg;

   // register indices as printed; byte address is four times the index
   localparam logic [5:0]  IDX_CTRL      = 6'h00;
   localparam logic [5:0]  IDX_CAUSE     = 6'h01;
   localparam logic [5:0]  IDX_IPS2      = 6'h1a;
   localparam logic [7:0]  ADDR_CTRL     = {IDX_CTRL, 2'b00};
   localparam logic [7:0]  ADDR_CAUSE    = {IDX_CAUSE, 2'b00};
   localparam logic [7:0]  ADDR_IPS2     = {IDX_IPS2, 2'b00};

   // system_control field positions
   localparam int unsigned CTRL_DBG_BIT  = 5;
   localparam int unsigned CTRL_SWR_BIT  = 4;
   localparam int unsigned CTRL_STOP_LO  = 2;
   localparam int unsigned CTRL_WAIT_LO  = 0;

   // timer_input_source_select_2 field positions
   localparam int unsigned IPS2_TA1_BIT  = 4;
   localparam int unsigned IPS2_TA2_BIT  = 8;
   localparam int unsigned IPS2_TA3_BIT  = 12;

   // reset values
   localparam logic [15:0] CTRL_RST      = 16'h0000;
   localparam logic [15:0] CAUSE_RST     = 16'h0004;
   localparam logic [2:0]  IPS2_RST      = 3'h0;

   // cycles the system reset output is held after the last source event
   localparam int unsigned SYS_RST_CYCLES = 16;

   typedef enum logic [1:0] {
      ST_RUN  = 2'b01,
      ST_HOLD = 2'b10
   } seq_state_e;

   // mode codes: bit 1 locks the field, bit 0 disables entry
   typedef struct packed {
      logic       dbg_on;
      logic [1:0] stop_dis;
      logic [1:0] wait_dis;
   } ctrl_s;

   // laid out as bits 6..2 of reset_cause_status
   typedef struct packed {
      logic sw;
      logic wto;
      logic wlor;
      logic ext;
      logic por;
   } cause_s;

endpackage : rst_ctl_pkg

// ===== core/pin_sync.sv
`timescale 1ns/1ps
module pin_sync #(
   parameter int unsigned      WIDTH = 1,
   parameter logic [WIDTH-1:0] IDLE  = '0
) (
   // clock and reset
   input  wire logic             clk,
   input  wire logic             rst_n,
   // asynchronous levels in, filtered levels out
   input  wire logic [WIDTH-1:0] din,
   output logic      [WIDTH-1:0] dout
);

   logic [WIDTH-1:0] s1_r, s2_r, s3_r, q_r;
   logic [WIDTH-1:0] s1_nxt, s2_nxt, s3_nxt, q_nxt;

   // s1 feeds s2 only; a change is taken core_debug_port s2 and s3 agree
   for (genvar i = 0; i < WIDTH; i++) begin : g_bit
      always_comb begin
         s1_nxt[i] = din[i];
         s2_nxt[i] = s1_r[i];
         s3_nxt[i] = s2_r[i];
         q_nxt[i]  = (s2_r[i] == s3_r[i]) ? s3_r[i] : q_r[i];
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         s1_r <= IDLE;
         s2_r <= IDLE;
         s3_r <= IDLE;
         q_r  <= IDLE;
      end else begin
         s1_r <= s1_nxt;
         s2_r <= s2_nxt;
         s3_r <= s3_nxt;
         q_r  <= q_nxt;
      end
   end

   assign dout = q_r;

endmodule : pin_sync

// ===== core/sys_reset_ctl.sv
`timescale 1ns/1ps
// Behaviour
// [RULE1] debug clock: tap-gated at 0, always on at 1
// [RULE2] writing software reset bit resets device; reads zero
// [RULE3] stop field 00 allows stop, 01 blocks it
// [RULE4] stop codes 1x act as 0x and lock
// [RULE5] wait field 00 allows wait, 01 blocks it
// [RULE6] wait codes 1x act as 0x and lock
// [RULE7] software writes zero to reserved bits
// [RULE8] cause register read-only, refreshed every system reset
// [RULE9] cause cleared by power-on, then updated by precedence
// [RULE10] only the latest reset source stays flagged
// [RULE11] simultaneous: power-on, pin, lost ref, timeout, software
// [RULE12] pin held after power-on swaps power-on for external
// [RULE13] bit 6 flags software reset
// [RULE14] bit 5 flags watchdog timeout
// [RULE15] bit 4 flags watchdog lost reference
// [RULE16] either watchdog flag selects the watchdog vector
// [RULE17] bit 3 flags external pin reset
// [RULE18] power-on sets bit 2; reset value 0x0004
// [RULE19] software reset bit gives one pulse, stores nothing
// [RULE20] stop and wait entry granted only when field allows
module sys_reset_ctl #(
   parameter int unsigned SYS_RST_CYCLES = rst_ctl_pkg::SYS_RST_CYCLES
) (
   // clock and power-on reset
   input  wire logic        clk,
   input  wire logic        rst_n,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // reset sources
   input  wire logic        ext_reset_pin_n,
   input  wire logic        wdog_timeout,
   input  wire logic        wdog_lost_ref,
   // core side
   input  wire logic        core_tap_enabled,
   input  wire logic        core_stop_req,
   input  wire logic        core_wait_req,
   output logic             stop_enter,
   output logic             wait_enter,
   output logic             debug_clk_en,
   output logic             use_wdog_vector,
   output logic             sys_reset,
   // timer input source selection
   output logic      [2:0]  timer_src_sel
);

   localparam int unsigned CNT_W = $clog2(SYS_RST_CYCLES + 1);
   localparam logic [CNT_W-1:0] CNT_LOAD = CNT_W'(SYS_RST_CYCLES - 1);

   if (SYS_RST_CYCLES < 1) begin : g_bad_param
      $error("SYS_RST_CYCLES must be at least one");
   end

   // reset image of the stored control fields; the request bit has no storage
   localparam rst_ctl_pkg::ctrl_s CTRL_INIT = '{
      dbg_on:   rst_ctl_pkg::CTRL_RST[rst_ctl_pkg::CTRL_DBG_BIT],
      stop_dis: rst_ctl_pkg::CTRL_RST[rst_ctl_pkg::CTRL_STOP_LO +: 2],
      wait_dis: rst_ctl_pkg::CTRL_RST[rst_ctl_pkg::CTRL_WAIT_LO +: 2]
   };

   // external pin, three-stage filtered
   logic ext_pin_n_s;

   pin_sync #(
      .WIDTH (1),
      .IDLE  (1'b1)
   ) u_ext_sync (
      .clk   (clk),
      .rst_n (rst_n),
      .din   (ext_reset_pin_n),
      .dout  (ext_pin_n_s)
   );

   // ---------------- apb slave ----------------
   logic        setup_ph;
   logic        wr_acc;
   logic        hit_ctrl, hit_cause, hit_ips2;
   logic [31:0] rd_val;
   logic [31:0] prdata_r, prdata_nxt;
   logic        pready_r, pready_nxt;
   logic        pslverr_r, pslverr_nxt;

   rst_ctl_pkg::ctrl_s  ctrl_r, ctrl_nxt;
   rst_ctl_pkg::cause_s cause_r, cause_nxt;
   logic [2:0]          ips2_r, ips2_nxt;
   logic                sw_req_r, sw_req_nxt;

   assign setup_ph = psel && !penable;
   // a write lands only at the edge that completes the access
   assign wr_acc   = psel && penable && pready_r && pwrite;

   always_comb begin
      hit_ctrl  = 1'b0;
      hit_cause = 1'b0;
      hit_ips2  = 1'b0;
      if (paddr == rst_ctl_pkg::ADDR_CTRL) begin
         hit_ctrl = 1'b1;
      end else if (paddr == rst_ctl_pkg::ADDR_CAUSE) begin
         hit_cause = 1'b1;
      end else if (paddr == rst_ctl_pkg::ADDR_IPS2) begin
         hit_ips2 = 1'b1;
      end
   end

   always_comb begin
      rd_val = 32'h0000_0000;
      if (hit_ctrl) begin
         // request bit always reads zero
         rd_val = {26'h0, ctrl_r.dbg_on, 1'b0, ctrl_r.stop_dis, ctrl_r.wait_dis};  // see [RULE2]
      end else if (hit_cause) begin
         rd_val = {25'h0, cause_r, 2'b00};
      end else if (hit_ips2) begin
         rd_val = {19'h0, ips2_r[2], 3'h0, ips2_r[1], 3'h0, ips2_r[0], 4'h0};
      end
   end

   // one setup, one access cycle; data and error registered at setup
   always_comb begin
      pready_nxt  = setup_ph;
      prdata_nxt  = prdata_r;
      pslverr_nxt = pslverr_r;
      if (setup_ph) begin
         prdata_nxt  = pwrite ? 32'h0000_0000 : rd_val;
         pslverr_nxt = !(hit_ctrl || hit_cause || hit_ips2);
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         prdata_r  <= 32'h0000_0000;
         pready_r  <= 1'b0;
         pslverr_r <= 1'b0;
      end else begin
         prdata_r  <= prdata_nxt;
         pready_r  <= pready_nxt;
         pslverr_r <= pslverr_nxt;
      end
   end

   // ---------------- control register ----------------
   logic ctrl_wr;

   assign ctrl_wr = wr_acc && hit_ctrl && pstrb[0];

   always_comb begin
      ctrl_nxt   = ctrl_r;
      sw_req_nxt = 1'b0;
      ips2_nxt   = ips2_r;
      if (ctrl_wr && !sys_reset) begin
         ctrl_nxt.dbg_on = pwdata[rst_ctl_pkg::CTRL_DBG_BIT];
         // a locked field ignores writes until the next reset
         if (!ctrl_r.stop_dis[1]) begin
            ctrl_nxt.stop_dis = pwdata[rst_ctl_pkg::CTRL_STOP_LO +: 2];  // see [RULE4]
         end
         if (!ctrl_r.wait_dis[1]) begin
            ctrl_nxt.wait_dis = pwdata[rst_ctl_pkg::CTRL_WAIT_LO +: 2];  // see [RULE6]
         end
         sw_req_nxt = pwdata[rst_ctl_pkg::CTRL_SWR_BIT];  // see [RULE19]
      end
      if (wr_acc && hit_ips2 && !sys_reset) begin
         if (pstrb[0]) begin
            ips2_nxt[0] = pwdata[rst_ctl_pkg::IPS2_TA1_BIT];
         end
         if (pstrb[1]) begin
            ips2_nxt[1] = pwdata[rst_ctl_pkg::IPS2_TA2_BIT];
            ips2_nxt[2] = pwdata[rst_ctl_pkg::IPS2_TA3_BIT];
         end
      end
      // any system reset also clears the locks
      if (sys_reset) begin
         ctrl_nxt = CTRL_INIT;
         ips2_nxt = rst_ctl_pkg::IPS2_RST;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         ctrl_r   <= CTRL_INIT;
         sw_req_r <= 1'b0;
         ips2_r   <= rst_ctl_pkg::IPS2_RST;
      end else begin
         ctrl_r   <= ctrl_nxt;
         sw_req_r <= sw_req_nxt;
         ips2_r   <= ips2_nxt;
      end
   end

   // ---------------- reset cause ----------------
   logic ext_evt;
   logic any_evt;

   assign ext_evt = !ext_pin_n_s;
   assign any_evt = ext_evt || wdog_lost_ref || wdog_timeout || sw_req_r;

   // the cause is rewritten, not accumulated, on each new source
   always_comb begin
      cause_nxt = cause_r;
      if (ext_evt) begin
         cause_nxt = '{sw: 1'b0, wto: 1'b0, wlor: 1'b0, ext: 1'b1, por: 1'b0};  // see [RULE11] [RULE12] [RULE17]
      end else if (wdog_lost_ref) begin
         cause_nxt = '{sw: 1'b0, wto: 1'b0, wlor: 1'b1, ext: 1'b0, por: 1'b0};  // see [RULE15] [RULE10]
      end else if (wdog_timeout) begin
         cause_nxt = '{sw: 1'b0, wto: 1'b1, wlor: 1'b0, ext: 1'b0, por: 1'b0};  // see [RULE14] [RULE10]
      end else if (sw_req_r) begin
         cause_nxt = '{sw: 1'b1, wto: 1'b0, wlor: 1'b0, ext: 1'b0, por: 1'b0};  // see [RULE13] [RULE8]
      end
   end

   // no bus path writes the cause register
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         cause_r <= rst_ctl_pkg::cause_s'(rst_ctl_pkg::CAUSE_RST[6:2]);  // see [RULE9] [RULE18]
      end else begin
         cause_r <= cause_nxt;
      end
   end

   // ---------------- system reset sequencer ----------------
   rst_ctl_pkg::seq_state_e state_r, state_nxt;
   logic [CNT_W-1:0]        cnt_r, cnt_nxt;
   logic                    sys_reset_r, sys_reset_nxt;

   always_comb begin
      state_nxt = state_r;
      cnt_nxt   = cnt_r;
      case (state_r)
         rst_ctl_pkg::ST_RUN: begin
            if (any_evt) begin
               state_nxt = rst_ctl_pkg::ST_HOLD;  // see [RULE2]
               cnt_nxt   = CNT_LOAD;
            end
         end
         rst_ctl_pkg::ST_HOLD: begin
            // a held pin or fresh source keeps the reset stretched
            if (any_evt) begin
               cnt_nxt = CNT_LOAD;
            end else if (cnt_r == '0) begin
               state_nxt = rst_ctl_pkg::ST_RUN;
            end else begin
               cnt_nxt = cnt_r - CNT_W'(1);
            end
         end
         default: begin
            state_nxt = rst_ctl_pkg::ST_RUN;
            cnt_nxt   = '0;
         end
      endcase
      sys_reset_nxt = (state_nxt == rst_ctl_pkg::ST_HOLD);
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state_r     <= rst_ctl_pkg::ST_RUN;
         cnt_r       <= '0;
         sys_reset_r <= 1'b0;
      end else begin
         state_r     <= state_nxt;
         cnt_r       <= cnt_nxt;
         sys_reset_r <= sys_reset_nxt;
      end
   end

   // ---------------- core side ----------------
   logic stop_enter_r, stop_enter_nxt;
   logic wait_enter_r, wait_enter_nxt;
   logic dbg_clk_r, dbg_clk_nxt;
   logic vec_r, vec_nxt;

   always_comb begin
      // low code bit alone decides; lock bit does not change the mode
      stop_enter_nxt = core_stop_req && !ctrl_r.stop_dis[0] && !sys_reset_r;  // see [RULE3] [RULE4] [RULE20]
      wait_enter_nxt = core_wait_req && !ctrl_r.wait_dis[0] && !sys_reset_r;  // see [RULE5] [RULE6] [RULE20]
      dbg_clk_nxt    = ctrl_r.dbg_on || core_tap_enabled;  // see [RULE1]
      vec_nxt        = cause_nxt.wto || cause_nxt.wlor;  // see [RULE16]
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         stop_enter_r <= 1'b0;
         wait_enter_r <= 1'b0;
         dbg_clk_r    <= 1'b0;
         vec_r        <= 1'b0;
      end else begin
         stop_enter_r <= stop_enter_nxt;
         wait_enter_r <= wait_enter_nxt;
         dbg_clk_r    <= dbg_clk_nxt;
         vec_r        <= vec_nxt;
      end
   end

   assign prdata          = prdata_r;
   assign pready          = pready_r;
   assign pslverr         = pslverr_r;
   assign stop_enter      = stop_enter_r;
   assign wait_enter      = wait_enter_r;
   assign debug_clk_en    = dbg_clk_r;
   assign use_wdog_vector = vec_r;
   assign sys_reset       = sys_reset_r;
   assign timer_src_sel   = ips2_r;

   // ---------------- assertions ----------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   sequence sw_write_s;
      psel && penable && pready_r && pwrite && paddr == rst_ctl_pkg::ADDR_CTRL
         && pstrb[0] && pwdata[4] && !sys_reset_r && state_r == rst_ctl_pkg::ST_RUN;
   endsequence

   sequence reset_seen_s;
      ##[1:3] sys_reset_r;
   endsequence

   swreq_read_zero_a: assert property (setup_ph && !pwrite && hit_ctrl |=> !prdata_r[4])  // see [RULE2]
      else $error("software reset request bit read back as one");
   swreset_pulse_a: assert property (sw_write_s |-> reset_seen_s ##0 cause_r.sw)  // see [RULE19]
      else $error("software reset write did not reset the device");
   stop_lock_a: assert property (ctrl_r.stop_dis[1] && !sys_reset_r |=> $stable(ctrl_r.stop_dis))  // see [RULE4]
      else $error("locked stop field changed");
   wait_lock_a: assert property (ctrl_r.wait_dis[1] && !sys_reset_r |=> $stable(ctrl_r.wait_dis))  // see [RULE6]
      else $error("locked wait field changed");
   stop_gate_a: assert property (core_stop_req && !sys_reset_r |=> stop_enter_r == !$past(ctrl_r.stop_dis[0]))  // see [RULE3]
      else $error("stop entry disagrees with stop field");
   wait_gate_a: assert property (core_wait_req && !sys_reset_r |=> wait_enter_r == !$past(ctrl_r.wait_dis[0]))  // see [RULE5]
      else $error("wait entry disagrees with wait field");
   cause_single_a: assert property ($onehot(cause_r))  // see [RULE10]
      else $error("reset cause holds other than one flag");
   por_value_a: assert property ($rose(rst_n) |-> cause_r == 5'h01)  // see [RULE18]
      else $error("power-on cause value wrong");
   ext_wins_a: assert property (ext_evt && (wdog_lost_ref || wdog_timeout || sw_req_r) |=> cause_r.ext)  // see [RULE11]
      else $error("external pin lost precedence");
   vector_sel_a: assert property (any_evt |=> use_wdog_vector == (cause_r.wto || cause_r.wlor))  // see [RULE16]
      else $error("reset vector select wrong");
   debug_clk_a: assert property (!ctrl_r.dbg_on && !core_tap_enabled |=> !dbg_clk_r)  // see [RULE1]
      else $error("debug clock ran without tap or enable");

endmodule : sys_reset_ctl

// ===== tb/core_wdog_model.sv
`timescale 1ns/1ps
module core_wdog_model (
   // clock
   input  wire logic       clk,
   // bench command: 1 timeout, 2 lost ref, 3 both, 4 pin, 7 stop and wait
   input  wire logic [2:0] cmd,
   // far-side sources
   output logic            ext_reset_pin_n,
   output logic            wdog_timeout,
   output logic            wdog_lost_ref,
   output logic            core_stop_req,
   output logic            core_wait_req
);
   logic [3:0] pin_cnt;

   // pin has a pull-up, so it returns high core_debug_port released
   assign ext_reset_pin_n = (pin_cnt == 4'h0);

   initial begin
      pin_cnt       = 4'h0;
      wdog_timeout  = 1'b0;
      wdog_lost_ref = 1'b0;
      core_stop_req = 1'b0;
      core_wait_req = 1'b0;
   end

   always @(posedge clk) begin
      wdog_timeout  <= (cmd == 3'h1) || (cmd == 3'h3);
      wdog_lost_ref <= (cmd == 3'h2) || (cmd == 3'h3);
      core_stop_req <= (cmd == 3'h7);
      core_wait_req <= (cmd == 3'h7);
      // held long enough to outlast the design's pin filter
      if (cmd == 3'h4) begin
         pin_cnt <= 4'h8;
      end else if (pin_cnt != 4'h0) begin
         pin_cnt <= pin_cnt - 4'h1;
      end
   end
endmodule : core_wdog_model

// ===== tb/sys_reset_ctl_bench.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin err_total++; \
   $display("wrong value %s exp %h got %h", nm, e, g); end end
module sys_reset_ctl_bench;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [3:0]  pstrb = 4'h0;
   logic [31:0] prdata;
   logic        pready, pslverr, ext_reset_pin_n, wdog_timeout, wdog_lost_ref;
   logic        core_tap_enabled = 1'b0;
   logic        core_stop_req, core_wait_req, stop_enter, wait_enter;
   logic        debug_clk_en, use_wdog_vector, sys_reset;
   logic [2:0]  cmd = 3'h0;
   logic [2:0]  tsel;
   logic [31:0] q;
   logic        e, s, w;
   int          err_total = 0;
   int          check_count = 0;
   int          cyc = 0;

   always #12.5 clk = ~clk;

   sys_reset_ctl #(.SYS_RST_CYCLES(2)) i_dut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .ext_reset_pin_n(ext_reset_pin_n), .wdog_timeout(wdog_timeout),
      .wdog_lost_ref(wdog_lost_ref), .core_tap_enabled(core_tap_enabled), .core_stop_req(core_stop_req),
      .core_wait_req(core_wait_req), .stop_enter(stop_enter), .wait_enter(wait_enter),
      .debug_clk_en(debug_clk_en), .use_wdog_vector(use_wdog_vector), .sys_reset(sys_reset),
      .timer_src_sel(tsel));

   core_wdog_model i_far (.clk(clk), .cmd(cmd), .ext_reset_pin_n(ext_reset_pin_n),
      .wdog_timeout(wdog_timeout), .wdog_lost_ref(wdog_lost_ref), .core_stop_req(core_stop_req),
      .core_wait_req(core_wait_req));

   task stop_test;
      if (err_total == 0 && check_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : stop_test

   always @(posedge clk) begin
      cyc++;
      if (cyc == 6000) begin
         err_total++;
         stop_test();
      end
   end

   task apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rd,
            output logic er);
      @(posedge clk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d; pstrb <= 4'hf;
      @(posedge clk);
      penable <= 1'b1;
      // only the bench timeout ends a wait for the answer
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task chk_rd(input logic [7:0] a, input logic [31:0] x);
      apb(1'b0, a, 32'h0, q, e);
      `CHK("read data", x, q)
   endtask : chk_rd

   task src(input logic [2:0] c);
      @(posedge clk);
      cmd <= c;
      @(posedge clk);
      cmd <= 3'h0;
   endtask : src

   task grant;
      s = 1'b0;
      w = 1'b0;
      src(3'h7);
      repeat (4) begin
         @(posedge clk);
         #1;
         s = s | stop_enter;
         w = w | wait_enter;
      end
   endtask : grant

   task wait_rst;
      int n;
      n = 0;
      while (sys_reset !== 1'b1 && n < 40) begin
         @(posedge clk);
         n++;
      end
      `CHK("sys_reset", 1'b1, sys_reset)
      while (sys_reset !== 1'b0 && n < 80) begin
         @(posedge clk);
         n++;
      end
   endtask : wait_rst

   task por(input logic pin);
      rst_n <= 1'b0;
      repeat (18) @(posedge clk);
      if (pin) cmd <= 3'h4;
      @(posedge clk);
      cmd <= 3'h0;
      @(posedge clk);
      rst_n <= 1'b1;
   endtask : por

   initial begin
      por(1'b0);
      chk_rd(rst_ctl_pkg::ADDR_CTRL, 32'h0);
      chk_rd(rst_ctl_pkg::ADDR_CAUSE, 32'h4);
      apb(1'b1, rst_ctl_pkg::ADDR_CAUSE, 32'h40, q, e);
      `CHK("cause write error", 1'b0, e)
      chk_rd(rst_ctl_pkg::ADDR_CAUSE, 32'h4);
      apb(1'b0, 8'h08, 32'h0, q, e);
      `CHK("unmapped error", 1'b1, e)
      `CHK("unmapped data", 32'h0, q)
      apb(1'b1, rst_ctl_pkg::ADDR_IPS2, 32'h1110, q, e);
      chk_rd(rst_ctl_pkg::ADDR_IPS2, 32'h1110);
      `CHK("timer select", 3'h7, tsel)
      // reserved bits always written as zero
      apb(1'b1, rst_ctl_pkg::ADDR_CTRL, 32'h25, q, e);
      chk_rd(rst_ctl_pkg::ADDR_CTRL, 32'h25);
      repeat (2) @(posedge clk);
      `CHK("debug clock", 1'b1, debug_clk_en)
      grant();
      `CHK("stop grant", 1'b0, s)
      `CHK("wait grant", 1'b0, w)
      apb(1'b1, rst_ctl_pkg::ADDR_CTRL, 32'h0a, q, e);
      repeat (2) @(posedge clk);
      `CHK("debug clock", 1'b0, debug_clk_en)
      core_tap_enabled <= 1'b1;
      repeat (3) @(posedge clk);
      `CHK("debug clock", 1'b1, debug_clk_en)
      core_tap_enabled <= 1'b0;
      grant();
      `CHK("stop grant", 1'b1, s)
      `CHK("wait grant", 1'b1, w)
      // locked fields keep their codes while the debug bit still lands
      apb(1'b1, rst_ctl_pkg::ADDR_CTRL, 32'h25, q, e);
      chk_rd(rst_ctl_pkg::ADDR_CTRL, 32'h2a);
      apb(1'b1, rst_ctl_pkg::ADDR_CTRL, 32'h10, q, e);
      wait_rst();
      chk_rd(rst_ctl_pkg::ADDR_CAUSE, 32'h40);
      chk_rd(rst_ctl_pkg::ADDR_CTRL, 32'h0);
      `CHK("timer select", 3'h0, tsel)
      src(3'h1);
      wait_rst();
      chk_rd(rst_ctl_pkg::ADDR_CAUSE, 32'h20);
      `CHK("vector select", 1'b1, use_wdog_vector)
      src(3'h3);
      wait_rst();
      chk_rd(rst_ctl_pkg::ADDR_CAUSE, 32'h10);
      // timeout lands while the filtered pin is still low, so both assert together
      src(3'h4);
      repeat (3) @(posedge clk);
      src(3'h1);
      wait_rst();
      chk_rd(rst_ctl_pkg::ADDR_CAUSE, 32'h08);
      `CHK("vector select", 1'b0, use_wdog_vector)
      por(1'b1);
      wait_rst();
      chk_rd(rst_ctl_pkg::ADDR_CAUSE, 32'h08);
      por(1'b0);
      chk_rd(rst_ctl_pkg::ADDR_CAUSE, 32'h04);
      stop_test();
   end
endmodule : sys_reset_ctl_bench
